//--- rtl/otp_consts.svh
`ifndef OTP_CONSTS_SVH
`define OTP_CONSTS_SVH
`define OTP_MEM_DEPTH 512
`define OTP_ADDR_W 9
`define OTP_DATA_W 8
`define OTP_FIFO_DEPTH 8
`define OTP_CLK_SYS_MHZ 125
`define OTP_OPT_PULSE_MS 150
`define OTP_OPT_PULSE_CYC (`OTP_OPT_PULSE_MS * 1000 * `OTP_CLK_SYS_MHZ)
`define OTP_LN_MAX_MHZ 4
`define OTP_SYS_MAX_MHZ 8
`define OTP_ERASED_BYTE 8'hFF
`define OTP_ZERO_ADDR 9'h000
`define OTP_ONE_ADDR 9'h001
`define OTP_CNT_W 25
`define OTP_CNT_ONE 25'h0000001
`endif

//--- rtl/otp_pkg.sv
package otp_pkg;
	typedef enum logic [2:0]
	{
		OTP_OP_IDLE = 3'b000,
		OTP_OP_READ = 3'b001,
		OTP_OP_PROG = 3'b010,
		OTP_OP_VERIFY = 3'b011,
		OTP_OP_OPTION = 3'b100
	} otp_op_t;
	typedef enum logic [2:0]
	{
		OTP_OPT_NONE = 3'b000,
		OTP_OPT_ROM_PROTECT = 3'b001,
		OTP_OPT_LOW_NOISE = 3'b010,
		OTP_OPT_AUTOLATCH_DIS = 3'b011,
		OTP_OPT_WATCHDOG = 3'b100,
		OTP_OPT_TEST_DIS = 3'b101
	} otp_opt_t;
endpackage : otp_pkg

//--- rtl/otp_fifo.sv
`timescale 1ns/10ps
`include "otp_consts.svh"
module otp_fifo
#(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
)
(
	input wire logic clk,
	input wire logic arstN,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed
	{
		logic [AW:0] wrPtr;
		logic [AW:0] rdPtr;
	} otp_fifo_st_t;
	otp_fifo_st_t s_q;
	otp_fifo_st_t s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic full;
	logic empty;
	logic push;
	logic pop;

	assign full = (s_q.wrPtr[AW] != s_q.rdPtr[AW]) && (s_q.wrPtr[AW-1:0] == s_q.rdPtr[AW-1:0]);
	assign empty = s_q.wrPtr == s_q.rdPtr;
	assign push = inValid && !full;
	assign pop = outReady && !empty;
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[s_q.rdPtr[AW-1:0]];

	always_comb
	begin
		s_d = s_q;
		if (push)
		begin
			s_d.wrPtr = s_q.wrPtr + 1'b1;
		end
		if (pop)
		begin
			s_d.rdPtr = s_q.rdPtr + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[s_q.wrPtr[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge clk or negedge arstN)
	begin
		if (!arstN)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end
endmodule : otp_fifo

//--- rtl/otp_program_port.sv
// Notes on behaviour
// - The programming data bus carries bytes both ways, out of the array and into it.
// - The device drives the data bus while output enable is low in read or verify, and releases it otherwise.
// - Read, program and verify act only while the chip select is low.
// - A high clear level forces the address counter to zero, over any counting.
// - Each address-clock cycle with clear low advances the address counter by exactly one.
// - A low program strobe writes the data-bus byte at the counter's address.
// - Read, program and verify are decoded from mode select, chip select, output enable and strobe.
// - With chip select at high voltage and strobe low, five option bits decode from mode select and output enable.
// - Once low noise is set, the divide-by-two is bypassed and the system clock is limited to 4 MHz.
`timescale 1ns/10ps
`include "otp_consts.svh"
module otp_program_port
	import otp_pkg::*;
#(
	parameter int DEPTH = `OTP_MEM_DEPTH,
	parameter int FIFO_DEPTH = `OTP_FIFO_DEPTH,
	parameter int OPT_PULSE_CYC = `OTP_OPT_PULSE_CYC
)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic linkClk,
	input wire logic linkArstN,
	input wire logic chipSelectN,
	input wire logic chipSelectHv,
	input wire logic outEnableN,
	input wire logic write_strobe_n,
	input wire logic prog_mode_select,
	input wire logic progModeSelectHv,
	input wire logic counter_clear_pin,
	input wire logic counter_clock_pin,
	input wire logic [`OTP_DATA_W-1:0] progDataIn,
	output logic [`OTP_DATA_W-1:0] progDataOut,
	output logic progDataOeN,
	output logic optRomProtect,
	output logic optLowNoise,
	output logic optAutoLatchDis,
	output logic watchdog_option,
	output logic optTestDis,
	output logic divBypass,
	output logic [3:0] system_timer_clock_max_mhz,
	output logic fifoStall
);
	localparam int AW = $clog2(DEPTH);
	localparam int FW = AW + `OTP_DATA_W;

	// Link-domain state: synchronised pins, counter, decode
	typedef struct packed
	{
		logic [1:0] csN;
		logic [1:0] csHv;
		logic [1:0] oeN;
		logic [1:0] pgmN;
		logic [1:0] ms;
		logic [1:0] msHv;
		logic [1:0] clr;
		logic [1:0] ck;
		// Data bus synchroniser
		logic [1:0][`OTP_DATA_W-1:0] din;
		logic ckLast;
		logic oeLast;
		logic pgmLast;
		logic [AW-1:0] addr;
		logic [`OTP_DATA_W-1:0] dout;
		logic oeDrvN;
		logic reqTgl;
		logic [AW-1:0] reqAddr;
		logic [1:0] ackSync;
		logic ackSeen;
		logic [1:0] optSync;
		logic [2:0] optCode;
		logic [`OTP_CNT_W-1:0] optCnt;
		logic optTgl;
	} otp_link_st_t;

	// System-domain state: array side
	typedef struct packed
	{
		logic [1:0] reqSync;
		logic reqSeen;
		logic ackTgl;
		logic [1:0] optTglSync;
		logic optSeen;
		logic stallMeta;
		logic [`OTP_DATA_W-1:0] rdByte;
		logic romProt;
		logic lowNoise;
		logic alDis;
		logic wdt;
		logic testDis;
		logic bypass;
		logic [3:0] maxMhz;
		logic stall;
	} otp_sys_st_t;

	otp_link_st_t l_q;
	otp_link_st_t l_d;
	otp_sys_st_t s_q;
	otp_sys_st_t s_d;
	logic [`OTP_DATA_W-1:0] mem [DEPTH];
	logic [FW-1:0] fifoInData;
	logic [FW-1:0] fifoOutData;
	logic fifoInValid;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoOutReady;
	logic wrStart;
	logic rdStart;
	logic ckRise;

	function automatic otp_op_t decodeOp(input logic csN, input logic csHv, input logic oeN,
		input logic pgmN, input logic ms, input logic msHv);
		otp_op_t op;
		op = OTP_OP_IDLE;
		if (csHv && !pgmN)
		begin
			op = OTP_OP_OPTION;
		end
		// main modes need chip select low
		else if (!csN && !csHv)
		begin
			if (msHv && !oeN && pgmN)
			begin
				op = OTP_OP_READ;
			end
			else if (!msHv && ms && oeN && !pgmN)
			begin
				op = OTP_OP_PROG;
			end
			else if (!msHv && ms && !oeN && pgmN)
			begin
				op = OTP_OP_VERIFY;
			end
		end
		return op;
	endfunction : decodeOp

	function automatic otp_opt_t decodeOpt(input logic oeN, input logic ms, input logic msHv);
		otp_opt_t o;
		if (msHv)
		begin
			o = oeN ? OTP_OPT_ROM_PROTECT : OTP_OPT_NONE;
		end
		else if (ms)
		begin
			o = oeN ? OTP_OPT_LOW_NOISE : OTP_OPT_AUTOLATCH_DIS;
		end
		else
		begin
			o = oeN ? OTP_OPT_WATCHDOG : OTP_OPT_TEST_DIS;
		end
		return o;
	endfunction : decodeOpt

	otp_op_t opNow;
	otp_opt_t optNow;
	assign opNow = decodeOp(l_q.csN[1], l_q.csHv[1], l_q.oeN[1], l_q.pgmN[1], l_q.ms[1], l_q.msHv[1]);
	assign optNow = decodeOpt(l_q.oeN[1], l_q.ms[1], l_q.msHv[1]);
	assign ckRise = l_q.ck[1] && !l_q.ckLast;
	// strobe falling edge while in program mode
	assign wrStart = (opNow == OTP_OP_PROG) && l_q.pgmLast;
	// one byte per output-enable falling edge
	assign rdStart = ((opNow == OTP_OP_READ) || (opNow == OTP_OP_VERIFY)) && l_q.oeLast;
	assign fifoInValid = wrStart;
	// write uses the counter's current value
	assign fifoInData = {l_q.addr, l_q.din[1]};

	always_comb
	begin
		l_d = l_q;
		l_d.csN = {l_q.csN[0], chipSelectN};
		l_d.csHv = {l_q.csHv[0], chipSelectHv};
		l_d.oeN = {l_q.oeN[0], outEnableN};
		l_d.pgmN = {l_q.pgmN[0], write_strobe_n};
		l_d.ms = {l_q.ms[0], prog_mode_select};
		l_d.msHv = {l_q.msHv[0], progModeSelectHv};
		l_d.clr = {l_q.clr[0], counter_clear_pin};
		l_d.ck = {l_q.ck[0], counter_clock_pin};
		// Data bus passes the same two stages as the strobe
		l_d.din = {l_q.din[0], progDataIn};
		l_d.ackSync = {l_q.ackSync[0], s_q.ackTgl};
		// Third stage marks the last answer taken
		l_d.ackSeen = l_q.ackSync[1];
		l_d.ckLast = l_q.ck[1];
		l_d.oeLast = l_q.oeN[1];
		l_d.pgmLast = l_q.pgmN[1];
		if (l_q.clr[1])
		begin
			l_d.addr = '0;
		end
		else if (ckRise)
		begin
			l_d.addr = l_q.addr + AW'(1);
		end
		if (rdStart)
		begin
			l_d.reqTgl = !l_q.reqTgl;
			// read uses the counter's current value
			l_d.reqAddr = l_q.addr;
		end
		// Answer toggle from the array side, past both stages
		if (l_q.ackSync[1] != l_q.ackSeen)
		begin
			l_d.dout = s_q.rdByte;
		end
		// drive only while output enable is low
		// bus turns round with output enable
		l_d.oeDrvN = !(((opNow == OTP_OP_READ) || (opNow == OTP_OP_VERIFY)) && !l_q.oeN[1]);
		// option latches only after the full pulse width
		if (opNow == OTP_OP_OPTION && optNow != OTP_OPT_NONE)
		begin
			if (l_q.optCode != optNow)
			begin
				l_d.optCode = optNow;
				l_d.optCnt = `OTP_CNT_ONE;
			end
			else if (l_q.optCnt == `OTP_CNT_W'(OPT_PULSE_CYC))
			begin
				l_d.optTgl = !l_q.optTgl;
				l_d.optCnt = l_q.optCnt + `OTP_CNT_ONE;
			end
			else if (l_q.optCnt < `OTP_CNT_W'(OPT_PULSE_CYC))
			begin
				l_d.optCnt = l_q.optCnt + `OTP_CNT_ONE;
			end
		end
		else
		begin
			l_d.optCode = OTP_OPT_NONE;
			l_d.optCnt = '0;
		end
	end

	always_ff @(posedge linkClk or negedge linkArstN)
	begin
		if (!linkArstN)
		begin
			l_q <= '0;
			l_q.csN <= 2'h3;
			l_q.oeN <= 2'h3;
			l_q.pgmN <= 2'h3;
			l_q.oeLast <= 1'b1;
			l_q.pgmLast <= 1'b1;
			l_q.oeDrvN <= 1'b1;
		end
		else
		begin
			l_q <= l_d;
		end
	end

	otp_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(linkClk),
		.arstN(linkArstN),
		.inValid(fifoInValid),
		.inReady(fifoInReady),
		.inData(fifoInData),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData(fifoOutData)
	);

	// Array write side drains the FIFO one word per link cycle
	assign fifoOutReady = 1'b1;

	always_ff @(posedge linkClk)
	begin
		if (fifoOutValid)
		begin
			mem[fifoOutData[FW-1:`OTP_DATA_W]] <= fifoOutData[`OTP_DATA_W-1:0];
		end
	end

	always_comb
	begin
		s_d = s_q;
		s_d.reqSync = {s_q.reqSync[0], l_q.reqTgl};
		s_d.reqSeen = s_q.reqSync[1];
		s_d.optTglSync = {s_q.optTglSync[0], l_q.optTgl};
		s_d.optSeen = s_q.optTglSync[1];
		// Full flag crosses through two stages
		s_d.stallMeta = !fifoInReady;
		s_d.stall = s_q.stallMeta;
		// Read address holds until the answer comes back
		if (s_q.reqSync[1] != s_q.reqSeen)
		begin
			s_d.rdByte = mem[l_q.reqAddr];
			s_d.ackTgl = !s_q.ackTgl;
		end
		// Option code holds while its toggle crosses
		if (s_q.optTglSync[1] != s_q.optSeen)
		begin
			unique case (otp_opt_t'(l_q.optCode))
				OTP_OPT_ROM_PROTECT: s_d.romProt = 1'b1;
				OTP_OPT_LOW_NOISE: s_d.lowNoise = 1'b1;
				OTP_OPT_AUTOLATCH_DIS: s_d.alDis = 1'b1;
				OTP_OPT_WATCHDOG: s_d.wdt = 1'b1;
				OTP_OPT_TEST_DIS: s_d.testDis = 1'b1;
				default: s_d.romProt = s_q.romProt;
			endcase
		end
		// low noise bypasses the divider and caps the clock
		s_d.bypass = s_q.lowNoise;
		s_d.maxMhz = s_q.lowNoise ? 4'(`OTP_LN_MAX_MHZ) : 4'(`OTP_SYS_MAX_MHZ);
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_q <= '0;
			s_q.maxMhz <= 4'(`OTP_SYS_MAX_MHZ);
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign progDataOut = l_q.dout;
	assign progDataOeN = l_q.oeDrvN;
	assign optRomProtect = s_q.romProt;
	assign optLowNoise = s_q.lowNoise;
	assign optAutoLatchDis = s_q.alDis;
	assign watchdog_option = s_q.wdt;
	assign optTestDis = s_q.testDis;
	assign divBypass = s_q.bypass;
	assign system_timer_clock_max_mhz = s_q.maxMhz;
	assign fifoStall = s_q.stall;
endmodule : otp_program_port

//--- test/otp_program_port_monitor.sv
`timescale 1ns/10ps
module otp_program_port_monitor
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic linkClk,
	input wire logic linkArstN,
	input wire logic chipSelectN,
	input wire logic outEnableN,
	input wire logic progModeSelectHv,
	input wire logic progDataOeN,
	input wire logic optRomProtect,
	input wire logic optLowNoise,
	input wire logic watchdog_option,
	input wire logic divBypass,
	input wire logic [3:0] system_timer_clock_max_mhz
);
	a_oe_release: assert property (@(posedge linkClk) disable iff (!linkArstN)
		outEnableN [*4] |-> progDataOeN) else $error("bus driven with enable high");
	a_cs_gates_drive: assert property (@(posedge linkClk) disable iff (!linkArstN)
		chipSelectN [*4] |-> progDataOeN) else $error("bus driven without select");
	a_read_answer: assert property (@(posedge linkClk) disable iff (!linkArstN)
		!chipSelectN && progModeSelectHv && $fell(outEnableN) |-> ##[1:4] !progDataOeN)
		else $error("read did not drive bus");
	a_ln_bypass: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$rose(optLowNoise) |-> ##[0:3] divBypass) else $error("divider not bypassed");
	a_ln_max: assert property (@(posedge clk_sys) disable iff (!arst_n)
		divBypass |-> ##[0:1] system_timer_clock_max_mhz == 4'h4) else $error("max not 4");
	a_normal_max: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!optLowNoise && !divBypass |-> system_timer_clock_max_mhz == 4'h8) else $error("max not 8");
	a_ln_sticky: assert property (@(posedge clk_sys) disable iff (!arst_n)
		optLowNoise |=> optLowNoise) else $error("low noise lost");
	a_rom_sticky: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!$fell(optRomProtect)) else $error("protect lost");
	a_wd_sticky: assert property (@(posedge clk_sys) disable iff (!arst_n)
		watchdog_option |-> ##1 watchdog_option [*2]) else $error("watchdog lost");
	c_read: cover property (@(posedge linkClk) $fell(progDataOeN));
	c_ln: cover property (@(posedge clk_sys) $rose(divBypass));
	c_wd: cover property (@(posedge clk_sys) $rose(watchdog_option));
endmodule : otp_program_port_monitor
bind otp_program_port otp_program_port_monitor mon_u (.clk_sys(clk_sys), .arst_n(arst_n),
	.linkClk(linkClk), .linkArstN(linkArstN), .chipSelectN(chipSelectN), .outEnableN(outEnableN),
	.progModeSelectHv(progModeSelectHv), .progDataOeN(progDataOeN), .optRomProtect(optRomProtect),
	.optLowNoise(optLowNoise), .watchdog_option(watchdog_option), .divBypass(divBypass),
	.system_timer_clock_max_mhz(system_timer_clock_max_mhz));

//--- test/otp_prog_model.sv
`timescale 1ns/10ps
module otp_prog_model
(
	input wire logic linkClk,
	input wire logic [7:0] progDataOut,
	input wire logic progDataOeN,
	output logic [7:0] progDataIn,
	output logic chipSelectN,
	output logic chipSelectHv,
	output logic outEnableN,
	output logic write_strobe_n,
	output logic prog_mode_select,
	output logic progModeSelectHv,
	output logic counter_clear_pin,
	output logic counter_clock_pin
);
	logic [7:0] dq;
	logic drv;
	// Bus released by both sides shows the inverse of the last byte
	assign progDataIn = !progDataOeN ? progDataOut : (drv ? dq : ~dq);
	// Every pin starts at a valid level
	initial
	begin
		{chipSelectN, chipSelectHv, outEnableN, write_strobe_n} = 4'hB;
		{prog_mode_select, progModeSelectHv, counter_clear_pin, counter_clock_pin} = 4'h0;
		dq = 8'h00;
		drv = 1'b0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge linkClk);
		#1;
	endtask : step
	task automatic adv();
		counter_clock_pin = 1'b1;
		step(4);
		counter_clock_pin = 1'b0;
		step(4);
	endtask : adv
	// Clear held high with a clock pulse inside
	task automatic clr();
		counter_clear_pin = 1'b1;
		step(4);
		adv();
		counter_clear_pin = 1'b0;
		step(4);
	endtask : clr
	task automatic wr(input logic [7:0] b);
		{chipSelectN, prog_mode_select, progModeSelectHv} = 3'b010;
		dq = b;
		drv = 1'b1;
		step(4);
		write_strobe_n = 1'b0;
		step(6);
		write_strobe_n = 1'b1;
		step(4);
		drv = 1'b0;
		chipSelectN = 1'b1;
		step(4);
	endtask : wr
	task automatic rd(input logic hv, input logic cs, output logic [7:0] b, output logic oe);
		{chipSelectN, prog_mode_select, progModeSelectHv} = {cs, 1'b1, hv};
		step(4);
		outEnableN = 1'b0;
		step(10);
		b = progDataIn;
		oe = progDataOeN;
		outEnableN = 1'b1;
		chipSelectN = 1'b1;
		step(4);
	endtask : rd
	// Strobe held past the option width
	task automatic opt(input logic [2:0] c);
		{progModeSelectHv, prog_mode_select, outEnableN} = c;
		{chipSelectN, chipSelectHv} = 2'b11;
		step(2);
		write_strobe_n = 1'b0;
		step(12);
		write_strobe_n = 1'b1;
		step(2);
		{chipSelectHv, outEnableN} = 2'b01;
		step(4);
	endtask : opt
endmodule : otp_prog_model

//--- test/otp_program_port_test.sv
`timescale 1ns/10ps
`define CHK(nm, ex, ac) begin compares++; if ((ac) !== (ex)) begin failCount++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, ac); end end
module otp_program_port_test;
	import otp_pkg::*;
	logic clk_sys, arst_n, linkClk, linkArstN, oe, divBypass, fifoStall, progDataOeN;
	logic chipSelectN, chipSelectHv, outEnableN, write_strobe_n, prog_mode_select;
	logic progModeSelectHv, counter_clear_pin, counter_clock_pin;
	logic [7:0] progDataIn, progDataOut, rb;
	logic [4:0] opts, e;
	logic [3:0] maxMhz;
	logic [2:0] optCode [5] = '{3'b111, 3'b011, 3'b010, 3'b001, 3'b000};
	int failCount = 0;
	int compares = 0;
	otp_program_port #(.OPT_PULSE_CYC(8)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .linkClk(linkClk),
		.linkArstN(linkArstN), .chipSelectN(chipSelectN), .chipSelectHv(chipSelectHv),
		.outEnableN(outEnableN), .write_strobe_n(write_strobe_n), .prog_mode_select(prog_mode_select),
		.progModeSelectHv(progModeSelectHv), .counter_clear_pin(counter_clear_pin),
		.counter_clock_pin(counter_clock_pin), .progDataIn(progDataIn), .progDataOut(progDataOut),
		.progDataOeN(progDataOeN), .optRomProtect(opts[4]), .optLowNoise(opts[3]),
		.optAutoLatchDis(opts[2]), .watchdog_option(opts[1]), .optTestDis(opts[0]),
		.divBypass(divBypass), .system_timer_clock_max_mhz(maxMhz), .fifoStall(fifoStall));
	otp_prog_model pm_u (.linkClk(linkClk), .progDataOut(progDataOut), .progDataOeN(progDataOeN),
		.progDataIn(progDataIn), .chipSelectN(chipSelectN), .chipSelectHv(chipSelectHv),
		.outEnableN(outEnableN), .write_strobe_n(write_strobe_n), .prog_mode_select(prog_mode_select),
		.progModeSelectHv(progModeSelectHv), .counter_clear_pin(counter_clear_pin),
		.counter_clock_pin(counter_clock_pin));
	task automatic conclude();
		$display("Compares %0d mismatches %0d", compares, failCount);
		if (failCount == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial
	begin
		linkClk = 1'b0;
		#7;
		forever #15 linkClk = ~linkClk;
	end
	initial
	begin
		#200000;
		failCount++;
		conclude();
	end
	initial
	begin
		arst_n = 1'b0;
		linkArstN = 1'b0;
		repeat (5) @(posedge clk_sys);
		#1;
		arst_n = 1'b1;
		linkArstN = 1'b1;
		`CHK("reset", 10'h208, {progDataOeN, opts, maxMhz})
		pm_u.step(4);
		pm_u.clr();
		pm_u.wr(8'hA5);
		pm_u.adv();
		pm_u.wr(8'h3C);
		pm_u.clr();
		pm_u.rd(1'b0, 1'b0, rb, oe);
		`CHK("verify0", 9'h0A5, {oe, rb})
		pm_u.rd(1'b1, 1'b0, rb, oe);
		`CHK("read0", 9'h0A5, {oe, rb})
		pm_u.adv();
		pm_u.rd(1'b1, 1'b0, rb, oe);
		`CHK("read1", 9'h03C, {oe, rb})
		pm_u.clr();
		pm_u.rd(1'b0, 1'b0, rb, oe);
		`CHK("cleared", 9'h0A5, {oe, rb})
		pm_u.rd(1'b1, 1'b1, rb, oe);
		`CHK("deselected", 1'b1, oe)
		for (int i = 0; i < 5; i++)
		begin
			pm_u.opt(optCode[i]);
			e = ~(5'h1F >> (i + 1));
			`CHK("options", e, opts)
		end
		`CHK("lownoise", 5'h14, {divBypass, maxMhz})
		`CHK("stall", 1'b0, fifoStall)
		conclude();
	end
endmodule : otp_program_port_test
